/* rcs_pkg.sv */
package rcs_pkg;
    localparam int PC_W = 21;
    localparam logic [PC_W-1:0] RESET_VEC = 21'h000000;
    localparam logic [PC_W-1:0] HI_VEC = 21'h000008;
    localparam logic [PC_W-1:0] LO_VEC = 21'h000018;
    localparam logic [PC_W-1:0] WAKE_STEP = 21'h000002;
    localparam logic [1:0] BOR_CFG_SOFT = 2'h1;
    // register offsets (data is 8 bits, low byte)
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_EVT = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_PC = 4'h3;
    // flag bit positions of the reset control register, then of the stack register
    localparam int B_BOR = 0;
    localparam int B_POR = 1;
    localparam int B_PD = 2;
    localparam int B_TO = 3;
    localparam int B_RI = 4;
    localparam int B_SOFT_BROWNOUT_EN = 6;
    localparam int B_UNF = 0;
    localparam int B_FUL = 1;
    localparam int N_EVT = 8;
    // power states of the core
    typedef enum logic [1:0] {
        PM_RUN = 2'h0,
        PM_LPRUN = 2'h1,
        PM_IDLE = 2'h3,
        PM_SLEEP = 2'h2
    } rcs_pm_t;
    // winning event, most severe first
    typedef enum logic [3:0] {
        EV_NONE = 4'h0,
        EV_BOR = 4'h1,
        EV_MASTER_CLEAR_IN = 4'h3,
        EV_WDT = 4'h2,
        EV_FUL = 4'h6,
        EV_UNF = 4'h7,
        EV_UNF_ERR = 4'h5,
        EV_RESET = 4'h4,
        EV_INT = 4'hc
    } rcs_ev_t;
endpackage

/* rcs_evt_if.sv */
`timescale 1ns/1ps
interface rcs_evt_if;
    import rcs_pkg::*;
    logic bor;
    logic master_clear_in;
    logic wdt;
    logic ful;
    logic unf;
    logic rst_instr;
    logic int_wake;
    rcs_ev_t ev;
    modport arb(input bor, master_clear_in, wdt, ful, unf, rst_instr, int_wake, output ev);
    modport core(output bor, master_clear_in, wdt, ful, unf, rst_instr, int_wake, input ev);
endinterface

/* rcs_arbiter.sv */
`timescale 1ns/1ps
module rcs_arbiter (
    input wire logic i_stack_fault_reset_en,
    rcs_evt_if.arb e
);
    import rcs_pkg::*;
    always_comb begin
        if (e.bor) begin // [RL17]
            e.ev = EV_BOR;
        end else if (e.master_clear_in) begin
            e.ev = EV_MASTER_CLEAR_IN;
        end else if (e.wdt) begin
            e.ev = EV_WDT;
        end else if (e.ful && i_stack_fault_reset_en) begin
            e.ev = EV_FUL;
        end else if (e.unf) begin
            e.ev = i_stack_fault_reset_en ? EV_UNF : EV_UNF_ERR;
        end else if (e.rst_instr) begin
            e.ev = EV_RESET;
        end else if (e.int_wake) begin
            e.ev = EV_INT;
        end else begin
            e.ev = EV_NONE;
        end
    end
endmodule

/* rcs_reset_cause.sv */
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
// Operation
// (RL1) plain registers keep contents on non-power-on resets; unknown only after power-on
// (RL2) watchdog wake-up resumes execution, leaving ordinary state untouched
// (RL3) power-on: pc zero, soft_brownout_en/ri/to/pd one, por/bor/stack flags zero
// (RL4) reset instruction: pc zero, clear ri only
// (RL5) brown-out: pc zero, ri/to/pd set, bor cleared
// (RL6) master clear in low-power run: pc zero, set to only
// (RL7) master clear in idle or sleep: pc zero, set to, clear pd
// (RL8) watchdog in run modes: pc zero, clear to only
// (RL9) master clear at full power: pc zero, flags unchanged
// (RL10) stack full with fault reset enabled: pc zero, set full flag
// (RL11) stack underflow with fault reset enabled: pc zero, set underflow flag
// (RL12) underflow without fault reset: no reset, underflow flag still set
// (RL13) watchdog in idle or sleep: continue pc plus 2, clear to and pd
// (RL14) interrupt wake from low power: clear pd, continue pc plus 2
// (RL15) interrupt wake with a global enable set loads the priority vector
// (RL16) soft brown-out enable: 1 at power-on, kept only if config 01 and set
// (RL17) coinciding sources: most severe one decides the flag update
module rcs_reset_cause (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_brownout,
    input wire logic i_master_clear_in,
    input wire logic i_wdt_timeout,
    input wire logic i_stack_full,
    input wire logic i_stack_underflow,
    input wire logic i_reset_instr,
    input wire logic i_int_wake,
    input wire logic i_int_hi,
    input wire logic i_stack_fault_reset_en,
    input wire logic i_high_prio_global_int_en,
    input wire logic i_low_prio_global_int_en,
    input wire logic [1:0] i_brownout_mode_cfg,
    input wire rcs_pkg::rcs_pm_t i_pm_state,
    input wire logic [rcs_pkg::PC_W-1:0] i_pc,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_core_reset,
    output logic o_pc_load,
    output logic [rcs_pkg::PC_W-1:0] o_pc,
    output logic o_reset_instr_flag_n,
    output logic o_wdt_timeout_flag_n,
    output logic o_powerdown_flag_n,
    output logic o_brownout_status_n,
    output logic o_stack_full_flag,
    output logic o_stack_underflow_flag,
    output logic o_irq
);
    import rcs_pkg::*;

    typedef struct packed {
        logic soft_brownout_en;
        logic ri;
        logic to;
        logic pd;
        logic por;
        logic bor;
        logic ful;
        logic unf;
        logic [N_EVT-1:0] evt;
        logic [N_EVT-1:0] mask;
        logic core_reset;
        logic pc_load;
        logic [PC_W-1:0] pc;
        logic [7:0] rdata;
        logic irq;
    } rcs_state_t;

    rcs_state_t s_r;
    rcs_state_t s_nxt;
    logic [1:0] master_clear_in_sync_r;
    logic [1:0] bor_sync_r;
    logic [1:0] wdt_sync_r;
    logic [1:0] master_clear_in_hist_r;
    logic [1:0] bor_hist_r;
    logic [1:0] wdt_hist_r;
    rcs_evt_if ev_bus ();

    function automatic logic rise(input logic [1:0] h);
        rise = h[0] & ~h[1];
    endfunction

    // two-flop synchronisers for the pin and analog sources
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            master_clear_in_sync_r <= 2'h0;
            bor_sync_r <= 2'h0;
            wdt_sync_r <= 2'h0;
            master_clear_in_hist_r <= 2'h0;
            bor_hist_r <= 2'h0;
            wdt_hist_r <= 2'h0;
        end else begin
            master_clear_in_sync_r <= {master_clear_in_sync_r[0], i_master_clear_in};
            bor_sync_r <= {bor_sync_r[0], i_brownout};
            wdt_sync_r <= {wdt_sync_r[0], i_wdt_timeout};
            master_clear_in_hist_r <= {master_clear_in_hist_r[0], master_clear_in_sync_r[1]};
            bor_hist_r <= {bor_hist_r[0], bor_sync_r[1]};
            wdt_hist_r <= {wdt_hist_r[0], wdt_sync_r[1]};
        end
    end

    assign ev_bus.bor = rise(bor_hist_r);
    assign ev_bus.master_clear_in = rise(master_clear_in_hist_r);
    assign ev_bus.wdt = rise(wdt_hist_r);
    assign ev_bus.ful = i_stack_full;
    assign ev_bus.unf = i_stack_underflow;
    assign ev_bus.rst_instr = i_reset_instr;
    assign ev_bus.int_wake = i_int_wake;

    rcs_arbiter u_arb (
        .i_stack_fault_reset_en(i_stack_fault_reset_en),
        .e(ev_bus.arb)
    );

    logic low_power;
    logic run_lp;
    logic [N_EVT-1:0] evt_set;
    logic [7:0] flags_rd;
    logic [7:0] stack_rd;
    logic soft_bor_ok;

    always_comb begin
        low_power = (i_pm_state == PM_IDLE) || (i_pm_state == PM_SLEEP);
        run_lp = (i_pm_state == PM_LPRUN);
        soft_bor_ok = (i_brownout_mode_cfg == BOR_CFG_SOFT) && s_r.soft_brownout_en;
        flags_rd = 8'h00;
        flags_rd[B_SOFT_BROWNOUT_EN] = s_r.soft_brownout_en;
        flags_rd[B_RI] = s_r.ri;
        flags_rd[B_TO] = s_r.to;
        flags_rd[B_PD] = s_r.pd;
        flags_rd[B_POR] = s_r.por;
        flags_rd[B_BOR] = s_r.bor;
        stack_rd = 8'h00;
        stack_rd[B_FUL] = s_r.ful;
        stack_rd[B_UNF] = s_r.unf;
        evt_set = '0;
        if (ev_bus.ev != EV_NONE) begin
            evt_set[ev_bus.ev[2:0]] = 1'b1;
        end
        if (ev_bus.ev == EV_INT) begin
            evt_set[N_EVT-1] = 1'b1;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.core_reset = 1'b0;
        s_nxt.pc_load = 1'b0;
        s_nxt.rdata = 8'h00;
        // any reset other than power-on keeps soft_brownout_en only when soft mode allows it
        if (ev_bus.ev inside {EV_BOR, EV_MASTER_CLEAR_IN, EV_WDT, EV_FUL, EV_UNF, EV_RESET}) begin
            if (!(ev_bus.ev == EV_WDT && low_power)) begin
                s_nxt.soft_brownout_en = soft_bor_ok; // [RL16]
            end
        end
        unique case (ev_bus.ev)
            EV_BOR: begin
                s_nxt.ri = 1'b1; // [RL5]
                s_nxt.to = 1'b1;
                s_nxt.pd = 1'b1;
                s_nxt.bor = 1'b0;
                s_nxt.core_reset = 1'b1;
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = RESET_VEC;
            end
            EV_MASTER_CLEAR_IN: begin
                if (low_power) begin
                    s_nxt.to = 1'b1; // [RL7]
                    s_nxt.pd = 1'b0;
                end else if (run_lp) begin
                    s_nxt.to = 1'b1; // [RL6]
                end
                s_nxt.core_reset = 1'b1; // [RL9]
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = RESET_VEC;
            end
            EV_WDT: begin
                s_nxt.to = 1'b0;
                s_nxt.pc_load = 1'b1;
                if (low_power) begin
                    s_nxt.pd = 1'b0; // [RL13]
                    s_nxt.pc = PC_W'(i_pc + WAKE_STEP); // [RL2]
                end else begin
                    s_nxt.core_reset = 1'b1; // [RL8]
                    s_nxt.pc = RESET_VEC;
                end
            end
            EV_FUL: begin
                s_nxt.ful = 1'b1; // [RL10]
                s_nxt.core_reset = 1'b1;
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = RESET_VEC;
            end
            EV_UNF: begin
                s_nxt.unf = 1'b1; // [RL11]
                s_nxt.core_reset = 1'b1;
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = RESET_VEC;
            end
            EV_UNF_ERR: begin
                s_nxt.unf = 1'b1; // [RL12]
            end
            EV_RESET: begin
                s_nxt.ri = 1'b0; // [RL4]
                s_nxt.core_reset = 1'b1;
                s_nxt.pc_load = 1'b1;
                s_nxt.pc = RESET_VEC;
            end
            EV_INT: begin
                if (i_pm_state != PM_RUN) begin
                    s_nxt.pd = 1'b0; // [RL14]
                    s_nxt.pc_load = 1'b1;
                    if (i_high_prio_global_int_en || i_low_prio_global_int_en) begin
                        s_nxt.pc = i_int_hi ? HI_VEC : LO_VEC; // [RL15]
                    end else begin
                        s_nxt.pc = PC_W'(i_pc + WAKE_STEP);
                    end
                end
            end
            EV_NONE: begin
            end
            default: begin
            end
        endcase
        // software register writes; hardware events win over clears of every bit but soft_brownout_en
        if (i_wr) begin
            unique case (i_addr)
                ADDR_FLAGS: begin
                    s_nxt.soft_brownout_en = i_wdata[B_SOFT_BROWNOUT_EN];
                    if (ev_bus.ev == EV_NONE) begin
                        s_nxt.ri = i_wdata[B_RI];
                        s_nxt.por = i_wdata[B_POR];
                        s_nxt.bor = i_wdata[B_BOR];
                    end
                end
                ADDR_EVT: s_nxt.evt = s_r.evt & ~i_wdata;
                ADDR_MASK: s_nxt.mask = i_wdata;
                default: begin
                end
            endcase
        end
        s_nxt.evt = s_nxt.evt | evt_set;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_FLAGS: s_nxt.rdata = flags_rd;
                ADDR_EVT: s_nxt.rdata = s_r.evt;
                ADDR_MASK: s_nxt.rdata = s_r.mask;
                ADDR_PC: s_nxt.rdata = stack_rd;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        s_nxt.irq = |(s_nxt.evt & s_nxt.mask);
    end

    // power-on state; all fields start at zero, then soft_brownout_en/ri/to/pd are set [RL1]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
            s_r.soft_brownout_en <= 1'b1; // [RL3]
            s_r.ri <= 1'b1;
            s_r.to <= 1'b1;
            s_r.pd <= 1'b1;
            s_r.pc <= RESET_VEC;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;
    assign o_core_reset = s_r.core_reset;
    assign o_pc_load = s_r.pc_load;
    assign o_pc = s_r.pc;
    assign o_reset_instr_flag_n = s_r.ri;
    assign o_wdt_timeout_flag_n = s_r.to;
    assign o_powerdown_flag_n = s_r.pd;
    assign o_brownout_status_n = s_r.bor;
    assign o_stack_full_flag = s_r.ful;
    assign o_stack_underflow_flag = s_r.unf;
    assign o_irq = s_r.irq;
endmodule

/* rcs_reset_cause_asserts.sv */
`timescale 1ns/1ps
module rcs_reset_cause_asserts
    import rcs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_brownout,
    input wire logic i_master_clear_in,
    input wire logic i_wdt_timeout,
    input wire logic i_stack_full,
    input wire logic i_stack_underflow,
    input wire logic i_reset_instr,
    input wire logic i_int_wake,
    input wire logic i_int_hi,
    input wire logic i_stack_fault_reset_en,
    input wire logic i_high_prio_global_int_en,
    input wire logic i_low_prio_global_int_en,
    input wire rcs_pkg::rcs_pm_t i_pm_state,
    input wire logic [rcs_pkg::PC_W-1:0] i_pc,
    input wire logic o_core_reset,
    input wire logic o_pc_load,
    input wire logic [rcs_pkg::PC_W-1:0] o_pc,
    input wire logic o_reset_instr_flag_n,
    input wire logic o_wdt_timeout_flag_n,
    input wire logic o_powerdown_flag_n,
    input wire logic o_brownout_status_n,
    input wire logic o_stack_full_flag,
    input wire logic o_stack_underflow_flag
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire pins = i_brownout | i_master_clear_in | i_wdt_timeout;
    wire stk = i_stack_full | i_stack_underflow;
    wire gie = i_high_prio_global_int_en | i_low_prio_global_int_en;
    wire en = i_stack_fault_reset_en;
    wire wake = i_int_wake && i_pm_state != PM_RUN && !pins && !stk && !i_reset_instr;
    property p_por;
        $rose(i_rstn) |-> o_reset_instr_flag_n && o_wdt_timeout_flag_n && o_powerdown_flag_n
            && !o_brownout_status_n && !o_stack_full_flag && !o_stack_underflow_flag;
    endproperty
    a_por: assert property (p_por) else $error("power-on flags wrong");
    property p_rsti;
        i_reset_instr && !pins && !stk |=> o_core_reset && o_pc == RESET_VEC
            && !o_reset_instr_flag_n && $stable(o_wdt_timeout_flag_n);
    endproperty
    a_rsti: assert property (p_rsti) else $error("reset instruction wrong");
    property p_full;
        i_stack_full && en && !pins |=> o_core_reset && o_stack_full_flag;
    endproperty
    a_full: assert property (p_full) else $error("stack full reset wrong");
    property p_unf_rst;
        i_stack_underflow && en && !pins && !i_stack_full
            |=> o_core_reset && o_stack_underflow_flag;
    endproperty
    a_unf_rst: assert property (p_unf_rst) else $error("underflow reset wrong");
    property p_unf_err;
        i_stack_underflow && !en && !pins && !i_stack_full
            |=> !o_core_reset && o_stack_underflow_flag;
    endproperty
    a_unf_err: assert property (p_unf_err) else $error("underflow error wrong");
    property p_int_vec;
        wake && gie |=> o_pc_load && !o_core_reset && o_pc == ($past(i_int_hi) ? HI_VEC : LO_VEC);
    endproperty
    a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");
    property p_int_pc;
        wake && !gie |=> o_pc_load && o_pc == $past(i_pc) + WAKE_STEP && !o_powerdown_flag_n;
    endproperty
    a_int_pc: assert property (p_int_pc) else $error("interrupt wake wrong");
    property p_bor;
        $rose(i_brownout) |-> ##[1:6] o_core_reset && !o_brownout_status_n && o_reset_instr_flag_n;
    endproperty
    a_bor: assert property (p_bor) else $error("brown-out reset wrong");
    property p_wdt_wake;
        $rose(i_wdt_timeout) && i_pm_state[1] |-> ##[1:6] o_pc_load && !o_core_reset
            && !o_wdt_timeout_flag_n && !o_powerdown_flag_n;
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");
endmodule
bind rcs_reset_cause rcs_reset_cause_asserts u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_brownout(i_brownout),
    .i_master_clear_in(i_master_clear_in), .i_wdt_timeout(i_wdt_timeout),
    .i_stack_full(i_stack_full), .i_stack_underflow(i_stack_underflow),
    .i_reset_instr(i_reset_instr), .i_int_wake(i_int_wake), .i_int_hi(i_int_hi),
    .i_stack_fault_reset_en(i_stack_fault_reset_en),
    .i_high_prio_global_int_en(i_high_prio_global_int_en),
    .i_low_prio_global_int_en(i_low_prio_global_int_en),
    .i_pm_state(i_pm_state), .i_pc(i_pc), .o_core_reset(o_core_reset),
    .o_pc_load(o_pc_load), .o_pc(o_pc), .o_reset_instr_flag_n(o_reset_instr_flag_n),
    .o_wdt_timeout_flag_n(o_wdt_timeout_flag_n), .o_powerdown_flag_n(o_powerdown_flag_n),
    .o_brownout_status_n(o_brownout_status_n), .o_stack_full_flag(o_stack_full_flag),
    .o_stack_underflow_flag(o_stack_underflow_flag)
);

/* rcs_reset_cause_bench.sv */
`timescale 1ns/1ps
module rcs_reset_cause_bench;
    import rcs_pkg::*;
    logic i_clk = 0;
    logic i_rstn = 0;
    logic [6:0] ev = '0;
    logic en = 0, hi = 0, gh = 0, gl = 0, wr = 0, rd = 0;
    logic [1:0] cfg = 2'h1;
    rcs_pm_t pm = PM_RUN;
    logic [20:0] pcv = '0;
    logic [3:0] addr = '0;
    logic [7:0] wd = '0, evt = '0;
    logic ri = 1, to = 1, pd = 1, por = 0, bor = 0, sb = 1, ful = 0, unf = 0;
    logic [31:0] seed = 32'h5d4158c6;
    int fail_count = 0, num_checks = 0;
    wire [7:0] o_rdata;
    wire o_core_reset, o_pc_load, o_irq;
    wire [20:0] o_pc;
    wire [5:0] fl;
    rcs_reset_cause u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_brownout(ev[0]),
        .i_master_clear_in(ev[1]), .i_wdt_timeout(ev[2]), .i_stack_full(ev[3]),
        .i_stack_underflow(ev[4]), .i_reset_instr(ev[5]), .i_int_wake(ev[6]), .i_int_hi(hi),
        .i_stack_fault_reset_en(en), .i_high_prio_global_int_en(gh),
        .i_low_prio_global_int_en(gl), .i_brownout_mode_cfg(cfg), .i_pm_state(pm), .i_pc(pcv),
        .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata),
        .o_core_reset(o_core_reset), .o_pc_load(o_pc_load), .o_pc(o_pc),
        .o_reset_instr_flag_n(fl[5]), .o_wdt_timeout_flag_n(fl[4]), .o_powerdown_flag_n(fl[3]),
        .o_brownout_status_n(fl[2]), .o_stack_full_flag(fl[1]), .o_stack_underflow_flag(fl[0]),
        .o_irq(o_irq));
    always #50 i_clk = ~i_clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge i_clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        addr <= a;
        rd <= 1;
        @(posedge i_clk);
        rd <= 0;
        #1 chk(o_rdata, e);
    endtask
    task automatic fire(input int s);
        logic rst, ld, act, wk, slp;
        logic [20:0] epc;
        int b, n;
        rst = 1;
        act = 1;
        b = s;
        n = 0;
        epc = RESET_VEC;
        wk = pm != PM_RUN;
        slp = pm[1];
        case (s)
            0: begin ri = 1; to = 1; pd = 1; bor = 0; b = 1; end
            1: begin b = 3; to = to | wk; pd = pd & !slp; end
            2: begin to = 0; if (slp) begin pd = 0; rst = 0; epc = pcv + WAKE_STEP; end end
            3: begin b = 6; act = en; ful = ful | en; end
            4: begin b = en ? 7 : 5; unf = 1; rst = en; end
            5: begin b = 4; ri = 0; end
            default: begin act = wk; rst = 0; pd = pd & !wk; b = 4;
                epc = (gh | gl) ? (hi ? HI_VEC : LO_VEC) : pcv + WAKE_STEP; end
        endcase
        ld = act & (rst | (s != 4));
        rst = rst & act;
        if (act || s == 6) evt[b] = 1;
        if (s == 6) evt[7] = 1;
        if (rst) sb = sb & (cfg == 2'h1);
        @(posedge i_clk);
        ev <= 7'(1 << s);
        if (s < 3) begin
            do begin @(posedge i_clk); #1; n++; end while (o_pc_load !== 1 && n < 10);
        end else begin
            @(posedge i_clk);
            ev <= '0;
            #1;
        end
        chk({o_core_reset, o_pc_load}, {rst, ld});
        if (ld) chk(o_pc, epc);
        chk(fl, {ri, to, pd, bor, ful, unf});
        @(posedge i_clk);
        ev <= '0;
        repeat (3) @(posedge i_clk);
    endtask
    task stop_test;
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #5000000;
        fail_count++;
        stop_test;
    end
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1;
        rreg(0, 8'h5c);
        rreg(3, 8'h00);
        rreg(4'h9, 8'h00);
        wreg(0, 8'h43);
        ri = 0;
        por = 1;
        bor = 1;
        rreg(0, {1'b0, sb, 1'b0, ri, to, pd, por, bor});
        wreg(2, 8'hff);
        repeat (80) begin
            r = rnd();
            @(posedge i_clk);
            pm <= rcs_pm_t'(r[1:0]);
            en <= r[2];
            hi <= r[3];
            gh <= r[4];
            gl <= r[5] & r[6];
            cfg <= {1'b0, r[7] | r[8] | r[9]};
            pcv <= r[31:11];
            @(posedge i_clk);
            fire(rnd() % 7);
        end
        rreg(1, evt);
        rreg(3, {6'b0, ful, unf});
        rreg(0, {1'b0, sb, 1'b0, ri, to, pd, por, bor});
        wreg(2, 8'h00);
        repeat (2) @(posedge i_clk);
        #1 chk(o_irq, 0);
        wreg(2, 8'hff);
        repeat (2) @(posedge i_clk);
        #1 chk(o_irq, |evt);
        wreg(1, 8'hff);
        repeat (2) @(posedge i_clk);
        #1 chk(o_irq, 0);
        rreg(1, 8'h00);
        stop_test;
    end
endmodule
